// ===== hdl/debug_probe_port.v
// Debug probe pin port: strap capture at reset release and debug output mux
//
// Overview of operation
// - While reset is held low all eight probe pins are inputs and are never driven.
// - After reset release the pins turn to outputs as the active selection allows.
// - The pin levels present at the moment of reset release are captured.
// - The captured value sets the test mode and stays unchanged until the next reset.
// - Only the low-to-high edge of reset samples the pins; later pin changes do nothing.
// - Pins rest low through internal pulldowns, so an unstrapped board captures zeros.
// - A low strap field of 000 leaves every probe pin in high impedance.
// - A low strap field of 010 drives the clock debug set with fixed levels on pins 3 to 6.
// - Strap-derived selections are only defaults; software may load a new one at any time outside reset and the capture cycle.
`timescale 1ns/100ps
`include "probe_map.vh"

module debug_probe_port #(
    parameter PIN_W = `PROBE_PIN_W,
    parameter SEL_W = `PROBE_SEL_W,
    parameter DIV_W = `PROBE_DIV_W
) (
    input  wire             clk_sys,
    input  wire             rst_n,
    input  wire [PIN_W-1:0] debug_probe_pins_in,
    output reg  [PIN_W-1:0] debug_probe_pins_out,
    output reg  [PIN_W-1:0] debug_probe_pins_oe,
    input  wire             sw_sel_wr,
    input  wire [SEL_W-1:0] sw_sel,
    input  wire             sw_div_wr,
    input  wire [DIV_W-1:0] sw_div,
    output reg  [PIN_W-1:0] strap_value_q,
    output reg  [SEL_W-1:0] probe_mode_strap_bits,
    output reg  [SEL_W-1:0] active_sel_q,
    output reg              probe_ready_q
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // These stages run through reset on purpose: the strap must already be
    // settled in the second stage when reset rises.
    reg [PIN_W-1:0] pin_meta_q;
    reg [PIN_W-1:0] pin_sync_q;

    always @(posedge clk_sys) begin
        pin_meta_q <= debug_probe_pins_in;
        pin_sync_q <= pin_meta_q;
    end

    // ****************************************
    // Reset release detection
    // ****************************************
    // The reset port is already synchronous to clk_sys; one flag is enough to
    // mark the first cycle after release.
    reg released_q;
    reg capture_pulse_q;

    // low level holds reset, rise releases
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            released_q <= 1'b0;
        end else begin
            released_q <= 1'b1;
        end
    end

    // one capture pulse per release edge
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            capture_pulse_q <= 1'b0;
        end else begin
            capture_pulse_q <= ~released_q;
        end
    end

    // ****************************************
    // Strap capture
    // ****************************************
    // latch synced pin levels at release
    // unstrapped pins read low by pulldown
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            strap_value_q         <= `PROBE_STRAP_RESET;
            probe_mode_strap_bits <= `PROBE_SEL_HIZ;
        end else if (!released_q) begin
            strap_value_q         <= pin_sync_q;
            probe_mode_strap_bits <= pin_sync_q[`PROBE_SEL_LSB +: SEL_W];
        end
    end

    // ****************************************
    // Active selection
    // ****************************************
    // strap holds until a software write or next reset
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            active_sel_q <= `PROBE_SEL_HIZ;
        end else if (!released_q) begin
            active_sel_q <= pin_sync_q[`PROBE_SEL_LSB +: SEL_W];
        end else if (sw_sel_wr) begin
            active_sel_q <= sw_sel;
        end
    end

    // Outputs only switch on once the selection has been loaded
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            probe_ready_q <= 1'b0;
        end else if (capture_pulse_q) begin
            probe_ready_q <= 1'b1;
        end
    end

    // ****************************************
    // Variable clock divisor
    // ****************************************
    reg [DIV_W-1:0] var_div_q;

    // software retunes the pin 2 clock
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            var_div_q <= `PROBE_PIN2_DIV_RESET;
        end else if (sw_div_wr) begin
            var_div_q <= sw_div;
        end
    end

    // ****************************************
    // Debug clock sources
    // ****************************************
    // Frequencies scale with clk_sys: the ratios between pins are exact, the
    // absolute rates are limited to half of clk_sys.
    wire clk_base;
    wire clk_half;
    wire clk_eighth;
    wire clk_var;

    probe_clk_div #(
        .DIV_W (DIV_W)
    ) u_clk_div (
        .clk_sys      (clk_sys),
        .rst_n        (rst_n),
        .var_div      (var_div_q),
        .clk_base_q   (clk_base),
        .clk_half_q   (clk_half),
        .clk_eighth_q (clk_eighth),
        .clk_var_q    (clk_var)
    );

    // ****************************************
    // Output selection
    // ****************************************
    reg [PIN_W-1:0] pin_out_d;
    reg [PIN_W-1:0] pin_oe_d;

    // Codes other than the two known ones stay quiet rather than guess
    function [2*PIN_W-1:0] sel_decode;
        input [SEL_W-1:0] sel;
        input             c_base;
        input             c_half;
        input             c_var;
        input             c_eighth;
        begin
            case (sel)
                `PROBE_SEL_CLKDBG: begin
                    sel_decode = {{PIN_W{1'b1}},
                                  c_eighth, `PROBE_CLKDBG_LEVELS, c_var, c_half, c_base};
                end
                `PROBE_SEL_HIZ: begin
                    sel_decode = {2*PIN_W{1'b0}};
                end
                default: begin
                    sel_decode = {2*PIN_W{1'b0}};
                end
            endcase
        end
    endfunction

    always @* begin
        {pin_oe_d, pin_out_d} = sel_decode(active_sel_q, clk_base, clk_half,
                                           clk_var, clk_eighth);
        if (!probe_ready_q) begin
            pin_oe_d  = {PIN_W{1'b0}};
            pin_out_d = {PIN_W{1'b0}};
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            debug_probe_pins_out <= {PIN_W{1'b0}};
            debug_probe_pins_oe  <= {PIN_W{1'b0}};
        end else begin
            debug_probe_pins_out <= pin_out_d;
            debug_probe_pins_oe  <= pin_oe_d;
        end
    end

endmodule // debug_probe_port

// ===== hdl/probe_clk_div.v
// Divided debug clock generator for the probe pins
`timescale 1ns/100ps
`include "probe_map.vh"

module probe_clk_div #(
    parameter DIV_W = `PROBE_DIV_W
) (
    input  wire             clk_sys,
    input  wire             rst_n,
    input  wire [DIV_W-1:0] var_div,
    output reg              clk_base_q,
    output reg              clk_half_q,
    output reg              clk_eighth_q,
    output reg              clk_var_q
);

    // ****************************************
    // Fixed ratio chain
    // ****************************************
    // Base toggles every cycle; the other taps keep the 2 and 8 ratios to it
    reg [3:0]       chain_q;
    reg [DIV_W-1:0] var_cnt_q;
    reg [DIV_W-1:0] var_lim;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            chain_q <= 4'h0;
        end else begin
            chain_q <= chain_q + 4'h1;
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            clk_base_q   <= 1'b0;
            clk_half_q   <= 1'b0;
            clk_eighth_q <= 1'b0;
        end else begin
            clk_base_q   <= ~chain_q[0];
            clk_half_q   <= chain_q[`PROBE_PIN1_RATIO - 1];
            clk_eighth_q <= chain_q[`PROBE_PIN7_RATIO - 5];
        end
    end

    // ****************************************
    // Variable divider
    // ****************************************
    // Band limits are worked out at 32 bits and cut to the divisor width
    wire [31:0]      div_lo_full = `PROBE_PIN2_DIV_MIN;
    wire [31:0]      div_hi_full = `PROBE_PIN2_DIV_MAX;
    wire [DIV_W-1:0] div_lo      = div_lo_full[DIV_W-1:0];
    wire [DIV_W-1:0] div_hi      = div_hi_full[DIV_W-1:0];

    // Out-of-band divisors are clamped so the band edges always hold
    always @* begin
        var_lim = var_div;
        if (var_div < div_lo) begin
            var_lim = div_lo;
        end else if (var_div > div_hi) begin
            var_lim = div_hi;
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            var_cnt_q <= {DIV_W{1'b0}};
            clk_var_q <= 1'b0;
        end else if (var_cnt_q >= var_lim - 1'b1) begin
            var_cnt_q <= {DIV_W{1'b0}};
            clk_var_q <= ~clk_var_q;
        end else begin
            var_cnt_q <= var_cnt_q + 1'b1;
        end
    end

endmodule // probe_clk_div

// ===== hdl/probe_map.vh
// Constants for the debug probe pin port: strap codes, fixed levels, clock ratios
`ifndef PROBE_MAP_VH
`define PROBE_MAP_VH

// ****************************************
// Strap and selection codes
// ****************************************
`define PROBE_SEL_W          3
`define PROBE_PIN_W          8
`define PROBE_SEL_LSB        0
`define PROBE_SEL_HIZ        3'h0
`define PROBE_SEL_CLKDBG     3'h2
`define PROBE_STRAP_RESET    8'h00

// ****************************************
// Clock debug set
// ****************************************
// Fixed levels on pins 6..3 (pin 3 is bit 0)
`define PROBE_CLKDBG_LEVELS  4'hd
`define PROBE_LEVEL_LSB      3
// Documented pin frequencies in kHz
`define PROBE_PIN0_FREQ_KHZ  60000
`define PROBE_PIN1_FREQ_KHZ  30000
`define PROBE_PIN7_FREQ_KHZ  7500
`define PROBE_PIN2_MIN_KHZ   700
`define PROBE_PIN2_MAX_KHZ   22500
// Ratios to pin 0 derived from the frequencies
`define PROBE_PIN1_RATIO     (`PROBE_PIN0_FREQ_KHZ / `PROBE_PIN1_FREQ_KHZ)
`define PROBE_PIN7_RATIO     (`PROBE_PIN0_FREQ_KHZ / `PROBE_PIN7_FREQ_KHZ)
// Pin 2 divisor range spanned by its frequency band; the low end rounds up so
// the fastest setting never goes past the top of the band
`define PROBE_PIN2_DIV_NUM   (`PROBE_PIN0_FREQ_KHZ + `PROBE_PIN2_MAX_KHZ - 1)
`define PROBE_PIN2_DIV_MIN   (`PROBE_PIN2_DIV_NUM / `PROBE_PIN2_MAX_KHZ)
`define PROBE_PIN2_DIV_MAX   (`PROBE_PIN0_FREQ_KHZ / `PROBE_PIN2_MIN_KHZ)
`define PROBE_DIV_W          8
`define PROBE_PIN2_DIV_RESET 8'h08

`endif

// ===== testbench/debug_probe_port_tb_top.sv
// Self-checking bench for the debug probe pin port
`timescale 1ns/100ps
module debug_probe_port_tb_top;
    logic        clk_sys = 1'b0, rst_n = 1'b0, sw_sel_wr = 1'b0, sw_div_wr = 1'b0;
    logic [2:0]  strap_jumpers = 3'h0, sw_sel = 3'h0;
    logic [7:0]  sw_div = 8'h00;
    logic [31:0] rng = 32'h1ad2_0b94;
    wire  [7:0]  debug_probe_pins_in, debug_probe_pins_out, debug_probe_pins_oe, strap_value_q;
    wire  [2:0]  probe_mode_strap_bits, active_sel_q;
    wire         probe_ready_q;
    int          error_cnt, num_checks, cycles, exp_sel, exp_strap, exp_div;

    debug_probe_port DUT (.clk_sys, .rst_n, .debug_probe_pins_in, .debug_probe_pins_out,
        .debug_probe_pins_oe, .sw_sel_wr, .sw_sel, .sw_div_wr, .sw_div, .strap_value_q,
        .probe_mode_strap_bits, .active_sel_q, .probe_ready_q);
    probe_board_model u_board (.strap_jumpers, .debug_probe_pins_out, .debug_probe_pins_oe,
        .debug_probe_pins_in);

    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 10000) begin
            error_cnt++;
            summarize();
        end
    end

    function automatic logic [31:0] next_rand();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic do_reset(logic [2:0] code);
        @(negedge clk_sys);
        rst_n = 1'b0;
        strap_jumpers = code;
        repeat (3) @(negedge clk_sys);
        check("oe in reset", 8'h00, debug_probe_pins_oe);
        rst_n = 1'b1;
        {exp_strap, exp_sel, exp_div} = {32'(code), 32'(code), 32'd8};
        @(negedge clk_sys);
        check("strap", 8'(exp_strap), strap_value_q);
        check("mode bits", 8'(exp_strap), {5'h00, probe_mode_strap_bits});
        strap_jumpers = 3'(next_rand());
        repeat (3) @(negedge clk_sys);
        check("ready", 8'h01, {7'h00, probe_ready_q});
    endtask
    task automatic sw_write(logic [2:0] sel, logic [7:0] div);
        {sw_sel_wr, sw_div_wr, sw_sel, sw_div} = {2'h3, ~sel, div};
        @(negedge clk_sys);
        check("first write", {5'h00, ~sel}, {5'h00, active_sel_q});
        sw_sel = sel;
        @(negedge clk_sys);
        {sw_sel_wr, sw_div_wr} = 2'h0;
        exp_sel = sel;
        exp_div = div < 3 ? 3 : (div > 85 ? 85 : div);
        @(negedge clk_sys);
    endtask
    // Pins 0, 1, 2, 7 must hold each level for their own count of cycles
    task automatic watch(int n);
        int per[4], pin[4], run[4];
        logic [7:0] prev;
        per = '{1, 2, exp_div, 8};
        pin = '{0, 1, 2, 7};
        run = '{-1, -1, -1, -1};
        prev = debug_probe_pins_out;
        repeat (n) begin
            @(negedge clk_sys);
            check("selection", 8'(exp_sel), {5'h00, active_sel_q});
            check("strap kept", 8'(exp_strap), strap_value_q);
            check("oe", exp_sel == 2 ? 8'hff : 8'h00, debug_probe_pins_oe);
            if (exp_sel == 2) begin
                check("levels", 8'h0d, {4'h0, debug_probe_pins_out[6:3]});
                for (int k = 0; k < 4; k++) begin
                    if (debug_probe_pins_out[pin[k]] !== prev[pin[k]]) begin
                        if (run[k] > 0) check("half period", 8'(per[k]), 8'(run[k]));
                        run[k] = 0;
                    end
                    if (run[k] >= 0) run[k]++;
                end
            end
            prev = debug_probe_pins_out;
        end
    endtask

    initial begin
        for (int c = 0; c < 21; c++) begin
            if (c < 8 || c == 20)
                do_reset(c < 8 ? 3'(c) : 3'h2);
            else
                sw_write(c < 16 ? 3'(c) : 3'h2, c < 16 ? 8'(next_rand()) : 8'(c - 18));
            watch(c < 8 ? 40 : 200);
            $display("test %0d done", c);
        end
        summarize();
    end
endmodule // debug_probe_port_tb_top

// ===== testbench/probe_board_model.sv
// Board side of the probe pins: strap jumpers and pad pulldowns
`timescale 1ns/100ps
module probe_board_model (
    input  wire [2:0] strap_jumpers,
    input  wire [7:0] debug_probe_pins_out,
    input  wire [7:0] debug_probe_pins_oe,
    output wire [7:0] debug_probe_pins_in
);
    // pulldowns, jumpers on low three only
    wire [7:0] board_level = {5'h00, strap_jumpers};
    // released pin reads its jumper level or falls to its pulldown
    assign debug_probe_pins_in = (debug_probe_pins_oe & debug_probe_pins_out)
        | (~debug_probe_pins_oe & board_level);
endmodule // probe_board_model

// ===== testbench/probe_port_properties.sv
// Concurrent checks on the debug probe pin port
`timescale 1ns/100ps
module probe_port_properties (
    input wire       clk_sys,
    input wire       rst_n,
    input wire [7:0] debug_probe_pins_in,
    input wire [7:0] debug_probe_pins_out,
    input wire [7:0] debug_probe_pins_oe,
    input wire       sw_sel_wr,
    input wire [2:0] sw_sel,
    input wire       sw_div_wr,
    input wire [7:0] sw_div,
    input wire [7:0] strap_value_q,
    input wire [2:0] probe_mode_strap_bits,
    input wire [2:0] active_sel_q,
    input wire       probe_ready_q
);
    wire [7:0] po = debug_probe_pins_out;
    wire [7:0] oe = debug_probe_pins_oe;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence released;
        !rst_n ##1 rst_n;
    endsequence
    sequence dbg_on;
        oe == 8'hff;
    endsequence
    // Reset itself is the cause here, so these three are never disabled
    a_idle_reset: assert property (disable iff (1'b0) !rst_n |=> oe == 8'h00)
        else $error("pins driven in reset");
    a_ready_up: assert property (disable iff (1'b0) released ##1 rst_n
        |-> !probe_ready_q ##1 probe_ready_q) else $error("outputs late after release");
    a_strap_used: assert property (disable iff (1'b0) released |=>
        active_sel_q == probe_mode_strap_bits && probe_mode_strap_bits == strap_value_q[2:0]
        && strap_value_q == $past(debug_probe_pins_in, 3))
        else $error("strap not in force");
    a_strap_held: assert property ($past(rst_n) && $past(rst_n, 2)
        |-> $stable(strap_value_q)) else $error("strap changed after release");
    a_hiz_default: assert property (probe_ready_q && active_sel_q != 3'h2
        |=> oe == 8'h00) else $error("pins not released");
    a_fixed_levels: assert property (probe_ready_q && active_sel_q == 3'h2
        |=> dbg_on ##0 po[6:3] == 4'hd) else $error("debug levels wrong");
    a_base_clock: assert property (dbg_on[*2] |-> $changed(po[0]))
        else $error("base clock stalled");
    a_eighth_clock: assert property (dbg_on[*2] ##0 $changed(po[7]) ##1 dbg_on[*8]
        |-> $changed(po[7]) && $past(po[7]) == $past(po[7], 7)) else $error("eighth clock wrong");
    a_sw_select: assert property (probe_ready_q && sw_sel_wr
        |=> active_sel_q == $past(sw_sel)) else $error("selection write lost");
endmodule // probe_port_properties

bind debug_probe_port probe_port_properties u_props (.clk_sys, .rst_n, .debug_probe_pins_in,
    .debug_probe_pins_out, .debug_probe_pins_oe, .sw_sel_wr, .sw_sel, .sw_div_wr, .sw_div,
    .strap_value_q, .probe_mode_strap_bits, .active_sel_q, .probe_ready_q);
